// *** dv/kar_regs_asserts.sv ***
`timescale 1ns/1ns
module kar_regs_chk
  import kar_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] tx_byte,
  input wire logic tx_start,
  input wire logic brownout_flag,
  input wire logic brownout_chip_reset,
  input wire logic chip_reset_req,
  input wire logic keyboard_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_ar;
    reg_rd && reg_addr == KAR_AUX_OFS;
  endsequence
  sequence s_rxrd;
    rx_valid ##1 (reg_rd && reg_addr == KAR_SDB_OFS && !rx_valid);
  endsequence
  property p_tx;
    reg_wr && reg_addr == KAR_SDB_OFS |=> tx_start && tx_byte == $past(reg_wdata);
  endproperty
  a_tx: assert property (p_tx) else $error("tx load");
  property p_txq;
    !(reg_wr && reg_addr == KAR_SDB_OFS) |=> !tx_start;
  endproperty
  a_txq: assert property (p_txq) else $error("tx start");
  property p_rx;
    s_rxrd |=> reg_rdata == $past(rx_byte, 2);
  endproperty
  a_rx: assert property (p_rx) else $error("rx read");
  property p_rsv;
    s_ar |=> reg_rdata[1] == 1'b0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit");
  property p_kf;
    s_ar |=> reg_rdata[7] == $past(keyboard_irq);
  endproperty
  a_kf: assert property (p_kf) else $error("key flag read");
  property p_kst;
    keyboard_irq && !(reg_wr && reg_addr == KAR_AUX_OFS) |=> keyboard_irq;
  endproperty
  a_kst: assert property (p_kst) else $error("key flag lost");
  property p_srs;
    reg_wr && reg_addr == KAR_AUX_OFS && reg_wdata[3] |=> chip_reset_req;
  endproperty
  a_srs: assert property (p_srs) else $error("sw reset");
  property p_srq;
    !(reg_wr && reg_addr == KAR_AUX_OFS && reg_wdata[3]) |=> !chip_reset_req;
  endproperty
  a_srq: assert property (p_srq) else $error("stray reset");
  property p_bor;
    brownout_chip_reset |-> brownout_flag;
  endproperty
  a_bor: assert property (p_bor) else $error("brownout reset");
endmodule
bind kar_regs kar_regs_chk #(.PORT_W(PORT_W)) kar_regs_chk_i (.*);

// *** dv/testbench.sv ***
`timescale 1ns/1ns
module testbench
  import kar_pkg::*;
;
  logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, rx_valid = 0;
  logic brownout_flag = 0, power_down = 0, rc_tick = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rx_byte = 8'h00, port0_pins = 8'hFF;
  logic [6:0] irq_sources = 7'h00;
  logic [6:0] irq_gated;
  logic [7:0] reg_rdata, tx_byte, serial_node_match_addr;
  logic brownout_detector_power, brownout_chip_reset, chip_reset_req, tx_start;
  logic converter_power_on, data_pointer_choice, keyboard_irq;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  kar_regs kar_regs_i (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic tick();
    @(posedge sys_clk);
    rc_tick <= 1'b1;
    @(posedge sys_clk);
    rc_tick <= 1'b0;
  endtask
  task automatic t_sdb();
    wr(KAR_SDB_OFS, 8'hA5);
    chk({tx_start, tx_byte[6:0]}, 8'hA5);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_byte <= 8'h3C;
    // Read right behind the byte arrival
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= KAR_SDB_OFS;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 8'h3C);
    rd(KAR_SDB_OFS, 8'h3C);
    $display("sdb done");
  endtask
  task automatic t_kbd();
    wr(KAR_KPE_OFS, 8'h01);
    @(posedge sys_clk);
    port0_pins <= 8'hFD;
    repeat (3) @(posedge sys_clk);
    chk({7'h00, keyboard_irq}, 8'h00);
    port0_pins <= 8'hFC;
    repeat (3) @(posedge sys_clk);
    port0_pins <= 8'hFF;
    #1;
    chk({7'h00, keyboard_irq}, 8'h01);
    rd(KAR_AUX_OFS, 8'h80);
    wr(KAR_AUX_OFS, 8'h00);
    chk({7'h00, keyboard_irq}, 8'h00);
    $display("kbd done");
  endtask
  task automatic t_aux();
    wr(KAR_AUX_OFS, 8'h0F);
    chk({5'h00, chip_reset_req, converter_power_on, data_pointer_choice}, 8'h07);
    rd(KAR_AUX_OFS, 8'h05);
    chk({7'h00, chip_reset_req}, 8'h00);
    wr(KAR_AUX_OFS, 8'h00);
    chk({6'h00, converter_power_on, data_pointer_choice}, 8'h00);
    $display("aux done");
  endtask
  task automatic t_bo();
    @(posedge sys_clk);
    brownout_flag <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({6'h00, brownout_chip_reset, brownout_detector_power}, 8'h03);
    wr(KAR_AUX_OFS, 8'h20);
    chk({6'h00, brownout_chip_reset, brownout_detector_power}, 8'h01);
    wr(KAR_AUX_OFS, 8'h40);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({6'h00, brownout_chip_reset, brownout_detector_power}, 8'h00);
    wr(KAR_AUX_OFS, 8'h30);
    @(posedge sys_clk);
    power_down <= 1'b1;
    tick();
    repeat (2) @(posedge sys_clk);
    #1;
    chk({7'h00, brownout_detector_power}, 8'h00);
    repeat (15) tick();
    repeat (2) @(posedge sys_clk);
    #1;
    chk({7'h00, brownout_detector_power}, 8'h01);
    @(posedge sys_clk);
    power_down <= 1'b0;
    brownout_flag <= 1'b0;
    $display("bo done");
  endtask
  task automatic t_ie();
    @(posedge sys_clk);
    irq_sources <= 7'h7F;
    wr(KAR_IEM_OFS, 8'h7F);
    chk({1'b0, irq_gated}, 8'h00);
    wr(KAR_AUX_OFS, 8'h00);
    wr(KAR_IEM_OFS, 8'hFF);
    chk({1'b0, irq_gated}, 8'h5F);
    wr(KAR_AUX_OFS, 8'h20);
    for (int s = 0; s < 7; s++) begin
      wr(KAR_IEM_OFS, 8'h80 | (8'h01 << s));
      chk({1'b0, irq_gated}, 8'h01 << s);
    end
    rd(KAR_IEM_OFS, 8'hC0);
    wr(KAR_SNA_OFS, 8'h5A);
    chk(serial_node_match_addr, 8'h5A);
    rd(KAR_SNA_OFS, 8'h5A);
    rd(8'h00, 8'h00);
    $display("ie done");
  endtask
  task automatic tally_and_finish();
    $display("cmp %0d err %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    t_sdb();
    t_kbd();
    t_aux();
    t_bo();
    t_ie();
    tally_and_finish();
  end
endmodule

// *** hdl/kar_kbd_detect.sv ***
`timescale 1ns/1ns
module kar_kbd_detect
  import kar_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [W-1:0] port_pins,
  input wire logic [W-1:0] pin_enable,
  output logic fall_event
);
  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;
  logic [W-1:0] fell;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      // Enabled pin going low
      assign fell[i] = pin_enable[i] & prev_r[i] & ~port_pins[i];
    end
  endgenerate

  always_comb begin
    prev_nxt = port_pins;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_r <= '1;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign fall_event = |fell;
endmodule

// *** hdl/kar_lp_sampler.sv ***
`timescale 1ns/1ns
module kar_lp_sampler
  import kar_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic rc_tick,
  input wire logic detector_on,
  input wire logic low_power,
  input wire logic power_down,
  output logic detector_power
);
  logic [KAR_LP_W-1:0] slot_r;
  logic [KAR_LP_W-1:0] slot_nxt;
  logic pwr_r;
  logic pwr_nxt;

  always_comb begin
    slot_nxt = slot_r;
    if (rc_tick) begin
      slot_nxt = slot_r + 1'b1;
    end
    pwr_nxt = 1'b0;
    if (detector_on) begin
      if (low_power && power_down) begin
        pwr_nxt = (slot_r == KAR_LP_ON_SLOT);
      end else begin
        pwr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slot_r <= '0;
      pwr_r <= 1'b0;
    end else begin
      slot_r <= slot_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  assign detector_power = pwr_r;
endmodule

// *** hdl/kar_regs.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - Serial buffer: one address, separate receive and transmit 8-bit registers.
// - Keyboard enable bit n lets port 0 pin n raise keyboard interrupt.
// - Keyboard flag bit 7 set when enabled pin falls, software clears.
// - Aux bit 6 zero keeps brownout detector running, one disables it.
// - Aux bit 5 chooses brownout chip reset or brownout interrupt.
// - Aux bit 4 powers detector one slot in sixteen during power-down.
// - Writing one to aux bit 3 resets the whole chip.
// - Aux bit 2 enables the converter circuit.
// - Aux bit 0 selects primary or second data pointer.
// - Interrupt enable bit 7 gates every interrupt source except the keyboard interrupt.
// - Interrupt enable bits 6..0 enable individual sources.
module kar_regs
  import kar_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [PORT_W-1:0] port0_pins,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic [7:0] tx_byte,
  output logic tx_start,
  output logic [7:0] serial_node_match_addr,
  input wire logic brownout_flag,
  input wire logic power_down,
  input wire logic rc_tick,
  output logic brownout_detector_power,
  output logic brownout_chip_reset,
  output logic chip_reset_req,
  output logic converter_power_on,
  output logic data_pointer_choice,
  input wire logic [KAR_NSRC-1:0] irq_sources,
  output logic [KAR_NSRC-1:0] irq_gated,
  output logic keyboard_irq
);
  logic [7:0] rx_r, rx_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic txs_r, txs_nxt;
  logic [PORT_W-1:0] kpe_r, kpe_nxt;
  logic kbf_r, kbf_nxt;
  logic [7:0] aux_r, aux_nxt;
  logic [7:0] iem_r, iem_nxt;
  logic [7:0] sna_r, sna_nxt;
  logic software_chip_reinit_r, software_chip_reinit_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic kbd_fall;
  logic bo_mode_irq;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  kar_kbd_detect #(
    .W(PORT_W)
  ) u_kbd (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .port_pins(port0_pins),
    .pin_enable(kpe_r),
    .fall_event(kbd_fall)
  );

  kar_lp_sampler u_lp (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .rc_tick(rc_tick),
    .detector_on(~aux_r[KAR_AUX_BOD]),
    .low_power(aux_r[KAR_AUX_LPB]),
    .power_down(power_down),
    .detector_power(brownout_detector_power)
  );

  always_comb begin
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    txs_nxt = 1'b0;
    kpe_nxt = kpe_r;
    kbf_nxt = kbf_r;
    aux_nxt = aux_r;
    iem_nxt = iem_r;
    sna_nxt = sna_r;
    software_chip_reinit_nxt = 1'b0;
    rd_nxt = KAR_RST8;
    if (rx_valid) begin
      rx_nxt = rx_byte;
    end
    if (reg_wr) begin
      if (hit(reg_addr, KAR_SDB_OFS)) begin
        tx_nxt = reg_wdata;
        txs_nxt = 1'b1;
      end
      if (hit(reg_addr, KAR_KPE_OFS)) begin
        kpe_nxt = reg_wdata[PORT_W-1:0];
      end
      if (hit(reg_addr, KAR_AUX_OFS)) begin
        aux_nxt = reg_wdata & KAR_AUX_WMASK;
        kbf_nxt = reg_wdata[KAR_AUX_KBF];
        software_chip_reinit_nxt = reg_wdata[KAR_AUX_SRS];
      end
      if (hit(reg_addr, KAR_IEM_OFS)) begin
        iem_nxt = reg_wdata;
      end
      if (hit(reg_addr, KAR_SNA_OFS)) begin
        sna_nxt = reg_wdata;
      end
    end
    if (kbd_fall) begin
      kbf_nxt = 1'b1;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        KAR_SDB_OFS: rd_nxt = rx_r;
        KAR_KPE_OFS: rd_nxt = 8'(kpe_r);
        KAR_AUX_OFS: begin
          rd_nxt = aux_r;
          rd_nxt[KAR_AUX_KBF] = kbf_r;
          rd_nxt[KAR_AUX_SRS] = 1'b0;
        end
        KAR_IEM_OFS: rd_nxt = iem_r;
        KAR_SNA_OFS: rd_nxt = sna_r;
        default: rd_nxt = KAR_RST8;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_r <= KAR_RST8;
      tx_r <= KAR_RST8;
      txs_r <= 1'b0;
      kpe_r <= '0;
      kbf_r <= 1'b0;
      aux_r <= KAR_RST8;
      iem_r <= KAR_RST8;
      sna_r <= KAR_RST8;
      software_chip_reinit_r <= 1'b0;
      rd_r <= KAR_RST8;
    end else begin
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      txs_r <= txs_nxt;
      kpe_r <= kpe_nxt;
      kbf_r <= kbf_nxt;
      aux_r <= aux_nxt;
      iem_r <= iem_nxt;
      sna_r <= sna_nxt;
      software_chip_reinit_r <= software_chip_reinit_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign reg_rdata = rd_r;
  assign tx_byte = tx_r;
  assign tx_start = txs_r;
  assign serial_node_match_addr = sna_r;
  assign keyboard_irq = kbf_r;
  assign bo_mode_irq = aux_r[KAR_AUX_BOI];
  // detector must be on for a brownout to count
  assign brownout_chip_reset = brownout_flag & ~bo_mode_irq & ~aux_r[KAR_AUX_BOD];
  assign chip_reset_req = software_chip_reinit_r;
  assign converter_power_on = aux_r[KAR_AUX_ADC];
  assign data_pointer_choice = aux_r[KAR_AUX_DPS];

  genvar s;
  generate
    for (s = 0; s < KAR_NSRC; s++) begin : g_irq
      if (s == KAR_IE_BO) begin : g_bo
        assign irq_gated[s] = iem_r[KAR_IE_GLOBAL] & iem_r[s] & irq_sources[s] & bo_mode_irq;
      end else begin : g_other
        assign irq_gated[s] = iem_r[KAR_IE_GLOBAL] & iem_r[s] & irq_sources[s];
      end
    end
  endgenerate
endmodule

// *** inc/kar_pkg.sv ***
package kar_pkg;
  // Register offsets on the special function bus
  localparam logic [7:0] KAR_SDB_OFS = 8'h99;
  localparam logic [7:0] KAR_KPE_OFS = 8'hA1;
  localparam logic [7:0] KAR_AUX_OFS = 8'hA2;
  localparam logic [7:0] KAR_IEM_OFS = 8'hA8;
  localparam logic [7:0] KAR_SNA_OFS = 8'hA9;
  // Aux control field positions
  localparam int KAR_AUX_KBF = 7;
  localparam int KAR_AUX_BOD = 6;
  localparam int KAR_AUX_BOI = 5;
  localparam int KAR_AUX_LPB = 4;
  localparam int KAR_AUX_SRS = 3;
  localparam int KAR_AUX_ADC = 2;
  localparam int KAR_AUX_RSV = 1;
  localparam int KAR_AUX_DPS = 0;
  // Interrupt enable field positions
  localparam int KAR_IE_GLOBAL = 7;
  localparam int KAR_IE_ADC = 6;
  localparam int KAR_IE_BO = 5;
  localparam int KAR_IE_SER = 4;
  localparam int KAR_IE_T1 = 3;
  localparam int KAR_IE_X1 = 2;
  localparam int KAR_IE_T0 = 1;
  localparam int KAR_IE_X0 = 0;
  localparam int KAR_NSRC = 7;
  // Reset values
  localparam logic [7:0] KAR_RST8 = 8'h00;
  // Reserved bit mask for aux register writes
  localparam logic [7:0] KAR_AUX_WMASK = 8'h7D;
  // Low power sampling: on one slot out of this many
  localparam int KAR_LP_DIV = 16;
  localparam int KAR_LP_W = 4;
  localparam logic [3:0] KAR_LP_ON_SLOT = 4'h0;
endpackage
